//--- hdl/pluggable_mgmt_defs.vh
// timing counts and serial id constants for the module management block
// Notes on behaviour
// R01: start init only once transmit supply good
// R02: enable delay counts until full modulated output
// R03: fault output held low without safety circuit
// R04: latch fault, keep laser off until cleared
// R05: host holds laser-off request, then negates it
// R06: negation restarts init, fault clears if gone
// R07: persisting fault latches again until next attempt
// R08: guard against rapid clear attempts pulsing laser
// R09: signal-lost output is only a preliminary hint
// R10: definition lines carry serial id and presence
// R11: host alone drives the serial clock
// R12: capture on rising edge, drive on falling
// R13: bidirectional data, detect start and stop
// R14: byte memory, addresses from zero upward
// R15: device select bits fixed at zero
// R16: identification fields are write protected
// R17: laser-off request held at least ten microseconds
// R18: init done within three hundred milliseconds
// R19: fault flag raised within one hundred microseconds
// R20: presence line grounded, lines two, three serial
// R21: serial reads served during init or recovery
`ifndef PLUGGABLE_MGMT_DEFS_VH
`define PLUGGABLE_MGMT_DEFS_VH
`define CLK_KHZ 25000
`define T_RESET_US 10
`define T_ON_US 1000
`define T_INIT_MS 300
`define RETRY_GAP_US 1000
`define T_RESET_CYC ((`T_RESET_US * `CLK_KHZ + 999) / 1000)
`define T_ON_CYC ((`T_ON_US * `CLK_KHZ) / 1000)
`define T_INIT_CYC (`T_INIT_MS * `CLK_KHZ)
`define RETRY_GAP_CYC ((`RETRY_GAP_US * `CLK_KHZ) / 1000)
`define ID_DEV_ADDR 7'h50
`define ID_PROT_END 9'h080
`define ID_ADDR_W 8
`endif

//--- hdl/sync2.v
// two flip-flop synchroniser for asynchronous inputs
`default_nettype none
module sync2 #(
    parameter WIDTH = 1
) (
    input wire clk,
    input wire srst,
    input wire ce,
    input wire [WIDTH-1:0] d,
    output reg [WIDTH-1:0] q
);
    reg [WIDTH-1:0] meta_reg;

    // first stage feeds only the second
    always @(posedge clk) begin
        if (srst) begin
            meta_reg <= {WIDTH{1'b0}};
            q <= {WIDTH{1'b0}};
        end else if (ce) begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule
`default_nettype wire

//--- hdl/pluggable_module_mgmt.v
// transmitter management, signal-lost and serial id slave of a module
`include "pluggable_mgmt_defs.vh"
`default_nettype none
module pluggable_module_mgmt #(
    parameter SAFETY_IMPL = 1,
    parameter SETTLE_CYCLES = `T_ON_CYC,
    parameter RETRY_GAP_CYCLES = `RETRY_GAP_CYC,
    parameter RESET_HOLD_CYCLES = `T_RESET_CYC,
    parameter ID_DEPTH = 256
) (
    input wire clk,
    input wire srst,
    input wire ce,
    input wire transmit_supply_ok,
    input wire tx_disable,
    input wire laser_fault_detect,
    input wire rx_power_low,
    input wire prog_we,
    input wire [`ID_ADDR_W-1:0] prog_addr,
    input wire [7:0] prog_data,
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output reg sda_oe,
    output wire present_out,
    output wire present_oe,
    output reg optical_signal_lost,
    output reg tx_fault,
    output reg laser_enable
);
    localparam ST_WAIT_SUPPLY = 3'd0;
    localparam ST_INIT = 3'd1;
    localparam ST_RUN = 3'd2;
    localparam ST_DISABLED = 3'd3;
    localparam ST_FAULT = 3'd4;

    localparam SI_IDLE = 3'd0;
    localparam SI_DEV = 3'd1;
    localparam SI_WADR = 3'd2;
    localparam SI_WDAT = 3'd3;
    localparam SI_RDAT = 3'd4;
    localparam SI_ACK = 3'd5;
    localparam SI_MACK = 3'd6;

    wire [5:0] pins_s;
    wire supply_s = pins_s[0];
    wire disable_s = pins_s[1];
    wire fault_s = pins_s[2];
    wire los_s = pins_s[3];
    wire scl_s = pins_s[4];
    wire sda_s = pins_s[5];

    // the six status and serial pins pass two flip-flops first; the prog_we, prog_addr and prog_data inputs do not
    sync2 #(.WIDTH(6)) u_sync (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .d({sda_in, scl_in, rx_power_low, laser_fault_detect, tx_disable,
            transmit_supply_ok}),
        .q(pins_s)
    );

    // R10: no static codes, serial id only
    // R20: presence line grounded
    assign present_out = 1'b0;
    assign present_oe = 1'b1;
    // R13: open-drain data, only pulls low
    assign sda_out = 1'b0;

    reg [2:0] st_reg;
    reg [23:0] cnt_reg;
    reg [23:0] gap_reg;
    reg [15:0] hold_reg;
    reg pins_prev_disable;

    // transmitter state machine
    always @(posedge clk) begin
        if (srst) begin
            st_reg <= ST_WAIT_SUPPLY;
            cnt_reg <= 24'h00_0000;
            gap_reg <= 24'h00_0000;
            hold_reg <= 16'h0000;
            pins_prev_disable <= 1'b0;
        end else if (ce) begin
            if (gap_reg != 24'h00_0000)
                gap_reg <= gap_reg - 24'h00_0001;
            pins_prev_disable <= disable_s;
            // R17: measure how long laser-off is held
            if (!disable_s)
                hold_reg <= 16'h0000;
            else if (hold_reg != 16'hffff)
                hold_reg <= hold_reg + 16'h0001;
            if (!supply_s) begin
                st_reg <= ST_WAIT_SUPPLY;
            end else begin
                case (st_reg)
                    // R01: wait for good transmit supply
                    ST_WAIT_SUPPLY: begin
                        cnt_reg <= 24'h00_0000;
                        st_reg <= disable_s ? ST_DISABLED : ST_INIT;
                    end
                    // R02: settle until full modulated output
                    ST_INIT: begin
                        if (disable_s) begin
                            st_reg <= ST_DISABLED;
                        end else if (cnt_reg >= SETTLE_CYCLES - 1) begin
                            // R07: fault still there, latch again
                            if (fault_s && SAFETY_IMPL != 0) begin
                                st_reg <= ST_FAULT;
                                gap_reg <= RETRY_GAP_CYCLES[23:0];
                            end else begin
                                st_reg <= ST_RUN;
                            end
                        end else begin
                            cnt_reg <= cnt_reg + 24'h00_0001;
                        end
                    end
                    ST_RUN: begin
                        // R19: fault latched one cycle after sync, flag out the next
                        if (fault_s && SAFETY_IMPL != 0)
                            st_reg <= ST_FAULT;
                        else if (disable_s)
                            st_reg <= ST_DISABLED;
                    end
                    ST_DISABLED: begin
                        cnt_reg <= 24'h00_0000;
                        if (!disable_s)
                            st_reg <= ST_INIT;
                    end
                    // R04: latched until a clear attempt
                    ST_FAULT: begin
                        cnt_reg <= 24'h00_0000;
                        // R08: spaced attempts only
                        // R06: negation after long hold restarts init
                        if (!disable_s && pins_prev_disable &&
                            hold_reg >= RESET_HOLD_CYCLES &&
                            gap_reg == 24'h00_0000)
                            st_reg <= ST_INIT;
                    end
                    default: st_reg <= ST_WAIT_SUPPLY;
                endcase
            end
        end
    end

    // registered transmitter outputs
    always @(posedge clk) begin
        if (srst) begin
            tx_fault <= 1'b0;
            laser_enable <= 1'b0;
            optical_signal_lost <= 1'b0;
        end else if (ce) begin
            // R03: tied low without safety circuit
            // R18: fault negated once settle ends clean
            tx_fault <= (SAFETY_IMPL != 0) &&
                        (st_reg == ST_FAULT || st_reg == ST_INIT);
            laser_enable <= (st_reg == ST_INIT || st_reg == ST_RUN) &&
                            !disable_s;
            // R09: raw hint, no data checking
            optical_signal_lost <= los_s;
        end
    end

    // serial id memory and slave
    reg [7:0] mem [0:ID_DEPTH-1];
    reg [2:0] si_reg;
    reg [2:0] after_reg;
    reg [3:0] bit_reg;
    reg [7:0] sh_reg;
    reg [7:0] tx_reg;
    reg [`ID_ADDR_W-1:0] ptr_reg;
    reg nack_reg;
    reg scl_d;
    reg sda_d;
    integer i;

    wire scl_rise = scl_s && !scl_d;
    wire scl_fall = !scl_s && scl_d;
    wire start_c = scl_s && scl_d && sda_d && !sda_s;
    wire stop_c = scl_s && scl_d && !sda_d && sda_s;
    wire [7:0] rd_byte = mem[ptr_reg];

    // R21: slave runs regardless of transmitter state
    always @(posedge clk) begin
        if (srst) begin
            si_reg <= SI_IDLE;
            after_reg <= SI_IDLE;
            bit_reg <= 4'h0;
            sh_reg <= 8'h00;
            tx_reg <= 8'h00;
            ptr_reg <= {`ID_ADDR_W{1'b0}};
            nack_reg <= 1'b0;
            sda_oe <= 1'b0;
            scl_d <= 1'b0;
            sda_d <= 1'b0;
            for (i = 0; i < ID_DEPTH; i = i + 1)
                mem[i] <= 8'h00;
        end else if (ce) begin
            scl_d <= scl_s;
            sda_d <= sda_s;
            if (prog_we)
                mem[prog_addr] <= prog_data;
            // R13: start and stop recognised
            if (start_c) begin
                si_reg <= SI_DEV;
                bit_reg <= 4'h0;
                sda_oe <= 1'b0;
            end else if (stop_c) begin
                si_reg <= SI_IDLE;
                sda_oe <= 1'b0;
            end else if (scl_rise) begin
                // R12: capture on rising edge
                case (si_reg)
                    SI_DEV, SI_WADR, SI_WDAT: begin
                        sh_reg <= {sh_reg[6:0], sda_s};
                        bit_reg <= bit_reg + 4'h1;
                    end
                    SI_RDAT: bit_reg <= bit_reg + 4'h1;
                    SI_MACK: nack_reg <= sda_s;
                    default: bit_reg <= bit_reg;
                endcase
            end else if (scl_fall) begin
                // R11: all timing follows host clock
                // R12: drive on falling edge
                case (si_reg)
                    SI_DEV: if (bit_reg == 4'h8) begin
                        // R15: select bits fixed at zero
                        if (sh_reg[7:1] == `ID_DEV_ADDR) begin
                            sda_oe <= 1'b1;
                            si_reg <= SI_ACK;
                            after_reg <= sh_reg[0] ? SI_RDAT : SI_WADR;
                        end else begin
                            si_reg <= SI_IDLE;
                        end
                    end
                    SI_WADR: if (bit_reg == 4'h8) begin
                        // R14: word address from zero
                        ptr_reg <= sh_reg;
                        sda_oe <= 1'b1;
                        si_reg <= SI_ACK;
                        after_reg <= SI_WDAT;
                    end
                    SI_WDAT: if (bit_reg == 4'h8) begin
                        // R16: protected region ignores writes
                        if ({1'b0, ptr_reg} >= `ID_PROT_END)
                            mem[ptr_reg] <= sh_reg;
                        ptr_reg <= ptr_reg + 1'b1;
                        sda_oe <= 1'b1;
                        si_reg <= SI_ACK;
                        after_reg <= SI_WDAT;
                    end
                    SI_ACK: begin
                        bit_reg <= 4'h0;
                        if (after_reg == SI_RDAT) begin
                            // R14: sequential byte reads
                            tx_reg <= rd_byte;
                            sda_oe <= !rd_byte[7];
                            ptr_reg <= ptr_reg + 1'b1;
                        end else begin
                            sda_oe <= 1'b0;
                        end
                        si_reg <= after_reg;
                    end
                    SI_RDAT: begin
                        if (bit_reg == 4'h8) begin
                            sda_oe <= 1'b0;
                            si_reg <= SI_MACK;
                        end else begin
                            sda_oe <= !tx_reg[6];
                            tx_reg <= {tx_reg[6:0], 1'b0};
                        end
                    end
                    SI_MACK: begin
                        bit_reg <= 4'h0;
                        if (nack_reg) begin
                            si_reg <= SI_IDLE;
                            sda_oe <= 1'b0;
                        end else begin
                            tx_reg <= rd_byte;
                            sda_oe <= !rd_byte[7];
                            ptr_reg <= ptr_reg + 1'b1;
                            si_reg <= SI_RDAT;
                        end
                    end
                    default: sda_oe <= 1'b0;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

//--- testbench/mgmt_checker_assertions.sv
// port assertions for the module management block
`default_nettype none
module mgmt_checker #(
    parameter SAFETY_IMPL = 1,
    parameter SETTLE_CYCLES = 20
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic transmit_supply_ok,
    input wire logic tx_disable,
    input wire logic laser_fault_detect,
    input wire logic rx_power_low,
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic present_out,
    input wire logic present_oe,
    input wire logic optical_signal_lost,
    input wire logic tx_fault,
    input wire logic laser_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    int init_cnt;
    default clocking @(posedge clk);
    endclocking
    default disable iff (srst);
    sequence scl_high_s;
        scl_in [*4];
    endsequence
    sequence run_fault_s;
        SAFETY_IMPL != 0 && laser_enable && !tx_fault && laser_fault_detect
        && !tx_disable;
    endsequence
    // cycles with laser on and flag up
    always @(posedge clk) begin
        if (srst || !(tx_fault && laser_enable))
            init_cnt <= 0;
        else
            init_cnt <= init_cnt + 1;
    end
    pins_fixed_a: assert property (
        present_oe && !present_out && !sda_out) else $error("pin level");
    no_supply_a: assert property (
        !transmit_supply_ok [*5] |-> !laser_enable) else $error("no supply");
    laser_start_a: assert property (
        $rose(laser_enable) |-> $past(transmit_supply_ok, 2)
        && !$past(tx_disable, 2)) else $error("laser start");
    fault_kept_a: assert property (
        $fell(tx_fault) && transmit_supply_ok && !$past(tx_disable, 3)
        |-> $past(laser_enable)) else $error("fault flag dropped");
    fault_raise_a: assert property (
        run_fault_s |-> ##[1:6] (tx_fault && !laser_enable))
        else $error("fault not flagged");
    no_safety_a: assert property (
        SAFETY_IMPL == 0 |-> !tx_fault) else $error("flag without safety");
    init_bound_a: assert property (
        init_cnt <= SETTLE_CYCLES + 4) else $error("init too long");
    los_delay_a: assert property (
        !$past(srst, 3) && !$past(srst, 2) && !$past(srst)
        |-> optical_signal_lost == $past(rx_power_low, 3))
        else $error("signal lost late");
    sda_quiet_a: assert property (
        scl_high_s |-> $stable(sda_oe)) else $error("data moved, clock high");
endmodule
bind pluggable_module_mgmt mgmt_checker #(
    .SAFETY_IMPL(SAFETY_IMPL), .SETTLE_CYCLES(SETTLE_CYCLES)) chk_i (.*);
`default_nettype wire

//--- testbench/id_host.sv
// two-wire host model for the serial id lines
`default_nettype none
module id_host (
    output var logic scl,
    output var logic sda_low,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 1ps;
    // host owns the clock, idle high
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // one bit, data set while low, sampled while high
    task automatic bit_io(input logic d, output logic r);
        scl = 1'b0;
        #80 sda_low = !d;
        #80 scl = 1'b1;
        #80 r = sda;
        #80;
    endtask
    // start: data falls while clock high
    task automatic start();
        #13 scl = 1'b0;
        #80 sda_low = 1'b0;
        #80 scl = 1'b1;
        #160 sda_low = 1'b1;
        #160;
    endtask
    // stop: data rises while clock high
    task automatic stop();
        scl = 1'b0;
        #80 sda_low = 1'b1;
        #80 scl = 1'b1;
        #160 sda_low = 1'b0;
        #160;
    endtask
    // byte out msb first, then acknowledge level
    task automatic put(input logic [7:0] d, output logic ack_n);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r);
        bit_io(1'b1, ack_n);
    endtask
    // byte in msb first, then host ack or nack
    task automatic get(output logic [7:0] d, input logic nack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(nack, r);
    endtask
endmodule
`default_nettype wire

//--- testbench/pluggable_module_mgmt_tb_top.sv
// self-checking bench for the module management block
`default_nettype none
module pluggable_module_mgmt_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SETTLE = 20;
    logic clk, srst, transmit_supply_ok, tx_disable, laser_fault_detect;
    logic rx_power_low, prog_we, scl_in, sda_in, sda_out, sda_oe;
    logic present_out, present_oe, optical_signal_lost, tx_fault;
    logic laser_enable, host_low, ack_n, fault_nosafe;
    logic ce = 1'b1;
    logic [7:0] prog_addr, prog_data, b;
    logic [7:0] mem_m [256];
    int fail_count, comparisons, seed;
    pluggable_module_mgmt #(.SETTLE_CYCLES(SETTLE), .RETRY_GAP_CYCLES(40),
        .RESET_HOLD_CYCLES(5)) pluggable_module_mgmt_i (.*);
    pluggable_module_mgmt #(.SAFETY_IMPL(0), .SETTLE_CYCLES(SETTLE),
        .RETRY_GAP_CYCLES(10), .RESET_HOLD_CYCLES(5))
        pluggable_module_mgmt_nosafe_i (.*, .sda_out(), .sda_oe(),
        .present_out(), .present_oe(), .optical_signal_lost(),
        .tx_fault(fault_nosafe), .laser_enable());
    id_host host_i (.scl(scl_in), .sda_low(host_low), .sda(sda_in));
    // open-drain data wire with pull-up
    assign sda_in = !(host_low || (sda_oe && !sda_out));
    initial begin
        clk = 1'b0;
        forever #20 clk = !clk;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    // hold the laser-off request, drop it, let init run
    task automatic clear(input int hold);
        tx_disable = 1'b1;
        cyc(hold);
        tx_disable = 1'b0;
        cyc(SETTLE + 10);
    endtask
    task automatic setp(input logic [7:0] a);
        host_i.start();
        host_i.put(8'ha0, ack_n);
        chk(ack_n, 8'h00);
        host_i.put(a, ack_n);
        chk(ack_n, 8'h00);
    endtask
    task automatic rd(input logic [7:0] a, input int n);
        setp(a);
        host_i.start();
        host_i.put(8'ha1, ack_n);
        chk(ack_n, 8'h00);
        for (int i = 0; i < n; i++) begin
            host_i.get(b, i == n - 1);
            chk(b, mem_m[8'(a + i)]);
        end
        host_i.stop();
    endtask
    initial begin
        #3_000_000;
        fail_count++;
        report_and_stop();
    end
    initial begin
        seed = 95710;
        {srst, transmit_supply_ok, tx_disable, laser_fault_detect} = 4'h8;
        {rx_power_low, prog_we, prog_addr, prog_data} = 18'h0_0000;
        cyc(2);
        srst = 1'b0;
        cyc(10);
        chk(laser_enable, 8'h00);
        transmit_supply_ok = 1'b1;
        // factory load with random bytes
        for (int i = 0; i < 256; i++) begin
            mem_m[i] = 8'($random(seed));
            {prog_we, prog_addr, prog_data} = {1'b1, 8'(i), mem_m[i]};
            cyc(1);
        end
        prog_we = 1'b0;
        chk({tx_fault, laser_enable}, 8'h01);
        laser_fault_detect = 1'b1;
        cyc(8);
        laser_fault_detect = 1'b0;
        cyc(30);
        chk({tx_fault, laser_enable}, 8'h02);
        clear(2);
        chk({tx_fault, laser_enable}, 8'h02);
        laser_fault_detect = 1'b1;
        clear(8);
        chk({tx_fault, laser_enable}, 8'h02);
        laser_fault_detect = 1'b0;
        // retry inside the gap is ignored
        clear(8);
        chk({tx_fault, laser_enable}, 8'h02);
        tx_disable = 1'b1;
        cyc(8);
        tx_disable = 1'b0;
        setp(8'h7f);
        b = 8'($random(seed));
        host_i.put(~mem_m[8'h7f], ack_n);
        host_i.put(b, ack_n);
        chk(ack_n, 8'h00);
        host_i.stop();
        mem_m[8'h80] = b;
        rd(8'h7e, 4);
        rd(8'hff, 2);
        host_i.start();
        host_i.put(8'ha2, ack_n);
        chk(ack_n, 8'h01);
        host_i.stop();
        cyc(4);
        chk({tx_fault, laser_enable}, 8'h01);
        chk(fault_nosafe, 8'h00);
        // supply loss drops the laser, return reinitialises
        transmit_supply_ok = 1'b0;
        cyc(8);
        chk({tx_fault, laser_enable}, 8'h00);
        transmit_supply_ok = 1'b1;
        cyc(SETTLE + 10);
        chk({tx_fault, laser_enable}, 8'h01);
        repeat (16) begin
            rx_power_low = 1'($random(seed));
            cyc(4);
            chk(optical_signal_lost, rx_power_low);
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
